// ==== include/dps_pkg.sv ====
// Constants and types for the dual-port SRAM port controller.
// Assumes a 50 MHz core clock and the faster speed grade of the memory.
package dps_pkg;

   localparam int CLK_PERIOD_NS = 20;
   localparam int ADDR_W        = 14;
   localparam int DATA_W        = 16;
   localparam int LANES         = 2;
   localparam int CNT_W         = 4;

   // Pin timing of the memory, in ns
   localparam int T_RC_NS   = 20;
   localparam int T_AA_NS   = 20;
   localparam int T_PWE_NS  = 15;
   localparam int T_HZWE_NS = 12;
   localparam int T_SD_NS   = 15;
   localparam int T_WH_NS   = 15;
   localparam int BUSY_RELEASE_TO_DATA_NS  = 20;
   localparam int FLAG_UPDATE_PULSE_NS  = 10;
   localparam int FLAG_WRITE_TO_READ_TIME_NS = 5;

   // Least time to whole cycles, never below one
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : min_cycles

   localparam int WR_OE_NS = (T_HZWE_NS + T_SD_NS > T_PWE_NS) ?
                             (T_HZWE_NS + T_SD_NS) : T_PWE_NS;
   localparam int GAP_NS   = (FLAG_UPDATE_PULSE_NS > FLAG_WRITE_TO_READ_TIME_NS) ? FLAG_UPDATE_PULSE_NS : FLAG_WRITE_TO_READ_TIME_NS;

   localparam logic [CNT_W-1:0] RD_CYC    = CNT_W'(min_cycles(T_AA_NS));
   localparam logic [CNT_W-1:0] WR_CYC    = CNT_W'(min_cycles(T_PWE_NS));
   localparam logic [CNT_W-1:0] WR_OE_CYC = CNT_W'(min_cycles(WR_OE_NS));
   localparam logic [CNT_W-1:0] WH_CYC    = CNT_W'(min_cycles(T_WH_NS));
   localparam logic [CNT_W-1:0] BDD_CYC   = CNT_W'(min_cycles(BUSY_RELEASE_TO_DATA_NS));
   localparam logic [CNT_W-1:0] GAP_CYC   = CNT_W'(min_cycles(GAP_NS));
   // Strictly longer than one read cycle after supply is good
   localparam logic [CNT_W-1:0] PWRUP_CYC = CNT_W'(min_cycles(T_RC_NS) + 1);

   // Pin levels at reset
   localparam logic PIN_INACTIVE = 1'b1;
   localparam logic DQ_OE_RESET  = 1'b0;

   typedef enum logic [1:0] {
      DPS_OP_READ,
      DPS_OP_WRITE,
      DPS_OP_CLAIM
   } dps_op_t;

endpackage : dps_pkg

// ==== verilog/dps_delay.sv ====
// Down counter that times how long a pin phase lasts.
// Assumes load values of at least one.
`timescale 1ns/100ps
module dps_delay #(
   parameter int W = 4
) (
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output logic              done
);
   logic [W-1:0] cnt;

   // Done after count cycles from the load edge
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= count - W'(1);
      end else if (cnt != '0) begin
         cnt <= cnt - W'(1);
      end
   end

   assign done = (cnt == '0) && !load;

endmodule : dps_delay

// ==== verilog/dps_host.sv ====
// Host controller for one port of an asynchronous dual-port SRAM.
// Assumes the memory pins are wired directly and inputs are synchronous.
`timescale 1ns/100ps
module dps_host
   import dps_pkg::*;
#(
   parameter int  AW             = dps_pkg::ADDR_W,
   parameter int  DW             = dps_pkg::DATA_W,
   parameter bit  WRITE_OE_LOW   = 1'b0
) (
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // User side
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire dps_pkg::dps_op_t       req_op,
   input  wire logic                   req_flag,
   input  wire logic [AW-1:0]          req_addr,
   input  wire logic [dps_pkg::LANES-1:0] req_lanes,
   input  wire logic [DW-1:0]          req_wdata,
   output logic                        resp_valid,
   output logic [DW-1:0]               resp_rdata,
   output logic                        resp_granted,
   input  wire logic                   retain_req,
   // Memory port pins
   output logic [AW-1:0]               mem_addr,
   output logic                        chip_select_n,
   output logic                        flag_select_n,
   output logic                        high_lane_select_n,
   output logic                        low_lane_select_n,
   output logic                        rw_n,
   output logic                        out_enable_n,
   output logic [DW-1:0]               dq_out,
   output logic                        dq_oe,
   input  wire logic [DW-1:0]          dq_in,
   input  wire logic                   busy_n_in
);
   import dps_pkg::*;

   localparam int LW = DW / LANES;

   typedef enum {
      ST_POWER,
      ST_IDLE,
      ST_RD,
      ST_RD_HOLD,
      ST_RD_BDD,
      ST_WR_SETUP,
      ST_WR_HOLD,
      ST_WR_WH,
      ST_WR_PULSE,
      ST_GAP
   } dps_state_t;

   dps_state_t             state;
   dps_op_t                op;
   logic                   is_flag;
   logic                   claim_second;
   logic [LANES-1:0]       lanes;
   logic [LANES-1:0]       next_lanes;
   logic                   t_load;
   logic [CNT_W-1:0]       t_count;
   logic                   t_done;
   logic                   capture;
   logic                   wr_done;
   logic [DW-1:0]          rd_masked;

   dps_delay #(
      .W        (CNT_W)
   ) u_delay (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .load     (t_load),
      .count    (t_count),
      .done     (t_done)
   );

   // No lane asked means both lanes, so an array access always has one
   assign next_lanes = (req_lanes == '0) ? {LANES{1'b1}} : req_lanes;

   assign capture = ((state == ST_RD) && t_done && busy_n_in) ||
                    ((state == ST_RD_BDD) && t_done && busy_n_in);
   assign wr_done = (state == ST_WR_PULSE) && t_done && busy_n_in;

   // Array read data masked to the lanes taken; flag reads pass unmasked
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         assign rd_masked[g*LW +: LW] = (lanes[g] || is_flag) ?
                                        dq_in[g*LW +: LW] : '0;
      end
   endgenerate

   // Sequencer and pin drive
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state              <= ST_POWER;
         op                 <= DPS_OP_READ;
         is_flag            <= 1'b0;
         claim_second       <= 1'b0;
         lanes              <= '0;
         req_ready          <= 1'b0;
         mem_addr           <= '0;
         chip_select_n      <= PIN_INACTIVE;
         flag_select_n      <= PIN_INACTIVE;
         high_lane_select_n <= PIN_INACTIVE;
         low_lane_select_n  <= PIN_INACTIVE;
         rw_n               <= PIN_INACTIVE;
         out_enable_n       <= PIN_INACTIVE;
         dq_out             <= '0;
         dq_oe              <= DQ_OE_RESET;
         t_load             <= 1'b1;
         t_count            <= PWRUP_CYC;
      end else begin
         t_load <= 1'b0;
         case (state)
            ST_POWER: begin
               // Reset release stands for supply good
               if (t_done && !t_load) begin
                  state     <= ST_IDLE;
                  req_ready <= !retain_req;
               end
            end
            ST_IDLE: begin
               req_ready <= !retain_req;
               if (req_valid && req_ready && !retain_req) begin
                  req_ready    <= 1'b0;
                  mem_addr     <= req_addr;
                  op           <= req_op;
                  is_flag      <= req_flag || (req_op == DPS_OP_CLAIM);
                  lanes        <= next_lanes;
                  claim_second <= 1'b0;
                  if (req_flag || (req_op == DPS_OP_CLAIM)) begin
                     chip_select_n <= 1'b1;
                     flag_select_n <= 1'b0;
                  end else begin
                     chip_select_n      <= 1'b0;
                     flag_select_n      <= 1'b1;
                     high_lane_select_n <= !next_lanes[1];
                     low_lane_select_n  <= !next_lanes[0];
                  end
                  if (req_op == DPS_OP_READ) begin
                     out_enable_n <= 1'b0;
                     t_load       <= 1'b1;
                     t_count      <= RD_CYC;
                     state        <= ST_RD;
                  end else begin
                     // Claim requests the flag by writing zero
                     dq_out       <= (req_op == DPS_OP_CLAIM) ? '0 : req_wdata;
                     dq_oe        <= 1'b1;
                     out_enable_n <= !WRITE_OE_LOW;
                     state        <= ST_WR_SETUP;
                  end
               end
            end
            ST_RD: begin
               if (!busy_n_in) begin
                  state <= ST_RD_HOLD;
               end else if (t_done) begin
                  state <= ST_GAP;
               end
            end
            ST_RD_HOLD: begin
               if (busy_n_in) begin
                  t_load  <= 1'b1;
                  t_count <= BDD_CYC;
                  state   <= ST_RD_BDD;
               end
            end
            ST_RD_BDD: begin
               if (!busy_n_in) begin
                  state <= ST_RD_HOLD;
               end else if (t_done) begin
                  state <= ST_GAP;
               end
            end
            ST_WR_SETUP: begin
               // Address and selects settled a cycle before the pulse
               if (busy_n_in) begin
                  rw_n    <= 1'b0;
                  t_load  <= 1'b1;
                  t_count <= WRITE_OE_LOW ? WR_OE_CYC : WR_CYC;
                  state   <= ST_WR_PULSE;
               end else begin
                  state <= ST_WR_HOLD;
               end
            end
            ST_WR_HOLD: begin
               if (busy_n_in) begin
                  t_load  <= 1'b1;
                  t_count <= WH_CYC;
                  state   <= ST_WR_WH;
               end
            end
            ST_WR_WH: begin
               if (!busy_n_in) begin
                  state <= ST_WR_HOLD;
               end else if (t_done) begin
                  rw_n    <= 1'b0;
                  t_load  <= 1'b1;
                  t_count <= WRITE_OE_LOW ? WR_OE_CYC : WR_CYC;
                  state   <= ST_WR_PULSE;
               end
            end
            ST_WR_PULSE: begin
               if (!busy_n_in) begin
                  // Lost arbitration: write was inhibited, redo it
                  rw_n  <= 1'b1;
                  state <= ST_WR_HOLD;
               end else if (t_done) begin
                  rw_n  <= 1'b1;
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               // Deselected phase doubles as flag update pulse
               if (t_done) begin
                  if ((op == DPS_OP_CLAIM) && !claim_second) begin
                     claim_second  <= 1'b1;
                     chip_select_n <= 1'b1;
                     flag_select_n <= 1'b0;
                     out_enable_n  <= 1'b0;
                     t_load        <= 1'b1;
                     t_count       <= RD_CYC;
                     state         <= ST_RD;
                  end else begin
                     req_ready <= !retain_req;
                     state     <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
         // Every phase ends deselected for the gap
         if (((state == ST_RD) || (state == ST_RD_BDD)) && capture) begin
            chip_select_n      <= 1'b1;
            flag_select_n      <= 1'b1;
            high_lane_select_n <= 1'b1;
            low_lane_select_n  <= 1'b1;
            out_enable_n       <= 1'b1;
            t_load             <= 1'b1;
            t_count            <= GAP_CYC;
         end
         if (wr_done) begin
            chip_select_n      <= 1'b1;
            flag_select_n      <= 1'b1;
            high_lane_select_n <= 1'b1;
            low_lane_select_n  <= 1'b1;
            out_enable_n       <= 1'b1;
            dq_oe              <= 1'b0;
            t_load             <= 1'b1;
            t_count            <= GAP_CYC;
         end
      end
   end

   // Answers to the user side
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         resp_valid   <= 1'b0;
         resp_rdata   <= '0;
         resp_granted <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         if (capture && (op == DPS_OP_READ)) begin
            resp_valid   <= 1'b1;
            resp_rdata   <= rd_masked;
            resp_granted <= 1'b0;
         end else if (capture && (op == DPS_OP_CLAIM)) begin
            // Low read-back of the flag means this port holds it
            resp_valid   <= 1'b1;
            resp_rdata   <= rd_masked;
            resp_granted <= !dq_in[0];
         end else if (wr_done && (op == DPS_OP_WRITE)) begin
            resp_valid   <= 1'b1;
            resp_rdata   <= '0;
            resp_granted <= 1'b0;
         end
      end
   end

endmodule : dps_host

// ==== tb/dps_host_properties.sv ====
// Pin-level assertions for the dual-port SRAM host controller.
// Assumes it is bound into dps_host and sees only that module's ports.
`timescale 1ns/100ps
module dps_host_properties
   import dps_pkg::*;
#(
   parameter int AW = dps_pkg::ADDR_W
) (
   input wire logic          core_clk,
   input wire logic          arst_n,
   input wire logic          req_ready,
   input wire logic          retain_req,
   input wire logic [AW-1:0] mem_addr,
   input wire logic          chip_select_n,
   input wire logic          flag_select_n,
   input wire logic          high_lane_select_n,
   input wire logic          low_lane_select_n,
   input wire logic          rw_n,
   input wire logic          out_enable_n,
   input wire logic          dq_oe,
   input wire logic          busy_n_in
);
   logic [1:0] up_cnt;

   default clocking dps_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   // Edges seen since reset release, saturating
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_cnt <= 2'h0;
      end
      else if (up_cnt != 2'h3) begin
         up_cnt <= up_cnt + 2'h1;
      end
   end

   chk_array_select: assert property (
      !chip_select_n |-> flag_select_n && !(high_lane_select_n && low_lane_select_n))
      else $error("array access without a lane");
   chk_flag_select: assert property (
      !flag_select_n |-> chip_select_n) else $error("flag access with chip select low");
   chk_read_no_write: assert property (
      !out_enable_n |-> rw_n) else $error("write strobe during read");
   chk_addr_moves: assert property (
      $changed(mem_addr) |-> rw_n && $past(rw_n)) else $error("address moved in write");
   chk_write_window: assert property (
      !rw_n |-> dq_oe && out_enable_n && $past(!chip_select_n || !flag_select_n))
      else $error("write strobe without prior select");
   chk_pulse_width: assert property (
      $fell(rw_n) |=> !rw_n || $past(!busy_n_in)) else $error("write pulse too short");
   chk_busy_holdoff: assert property (
      !busy_n_in || $rose(busy_n_in) |=> !$fell(rw_n)) else $error("write started under busy");
   chk_retain_idle: assert property (
      retain_req && req_ready |=> chip_select_n && !req_ready) else $error("taken in retention");
   chk_power_wait: assert property (
      req_ready || !chip_select_n || !flag_select_n |-> up_cnt >= 2'h2)
      else $error("access too soon after reset");
   chk_flag_gap: assert property (
      $rose(flag_select_n) |=> flag_select_n) else $error("flag update gap too short");
   chk_flag_addr: assert property (
      !flag_select_n && $past(!flag_select_n) |-> $stable(mem_addr))
      else $error("flag read by address change");
endmodule : dps_host_properties

bind dps_host dps_host_properties #(.AW(AW)) u_props (.core_clk, .arst_n, .req_ready,
   .retain_req, .mem_addr, .chip_select_n, .flag_select_n, .high_lane_select_n,
   .low_lane_select_n, .rw_n, .out_enable_n, .dq_oe, .busy_n_in);

// ==== tb/dps_mem_model.sv ====
// Behavioural model of one port of the dual-port SRAM with one flag.
// Assumes pins come straight from the host; busy and the far port come from the bench.
`timescale 1ns/100ps
module dps_mem_model
   import dps_pkg::*;
(
   input  wire logic                      core_clk,
   input  wire logic [dps_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic                      chip_select_n,
   input  wire logic                      flag_select_n,
   input  wire logic                      high_lane_select_n,
   input  wire logic                      low_lane_select_n,
   input  wire logic                      rw_n,
   input  wire logic                      out_enable_n,
   input  wire logic [dps_pkg::DATA_W-1:0] dq_out,
   input  wire logic                      dq_oe,
   output logic [dps_pkg::DATA_W-1:0]      dq_in,
   input  wire logic                      busy_hold,
   input  wire logic                      far_holds_flag,
   output logic                           busy_n_in
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] last = 16'h0000;
   logic              own  = 1'b0;
   logic              array_sel;
   logic              flag_sel;

   assign array_sel = !chip_select_n && flag_select_n;
   assign flag_sel  = chip_select_n && !flag_select_n;
   assign busy_n_in = !busy_hold;

   // Undriven pins show the inverse of the last value
   always_comb begin
      dq_in = ~last;
      if (rw_n && !out_enable_n && flag_sel) begin
         dq_in = {DATA_W{!own}};
      end
      else if (rw_n && !out_enable_n && array_sel) begin
         if (!high_lane_select_n) dq_in[15:8] = mem[mem_addr][15:8];
         if (!low_lane_select_n) dq_in[7:0] = mem[mem_addr][7:0];
      end
   end

   always @(posedge core_clk) begin
      last <= dq_in;
      if (!rw_n && busy_n_in && dq_oe) begin
         if (array_sel && !high_lane_select_n) mem[mem_addr][15:8] <= dq_out[15:8];
         if (array_sel && !low_lane_select_n) mem[mem_addr][7:0] <= dq_out[7:0];
         if (flag_sel) own <= !dq_out[0] && !far_holds_flag;
      end
   end
endmodule : dps_mem_model

// ==== tb/tb.sv ====
// Self-checking bench for the dual-port SRAM host controller.
// Assumes the memory model on the pins; busy and the far port are driven here.
`timescale 1ns/100ps
module tb;
   import dps_pkg::*;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              grant;
      logic              use_grant;
   } dps_exp_t;

   logic core_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_flag = 1'b0, retain_req = 1'b0;
   logic busy_hold = 1'b0, far_holds_flag = 1'b0, req_ready, resp_valid, resp_granted;
   logic rw_n, chip_select_n, flag_select_n, high_lane_select_n, low_lane_select_n;
   logic out_enable_n, dq_oe, busy_n_in;
   dps_op_t           req_op = DPS_OP_READ;
   logic [ADDR_W-1:0] req_addr = 14'h0000, mem_addr, a;
   logic [1:0]        req_lanes = 2'h0, lanes, rl;
   logic [DATA_W-1:0] req_wdata = 16'h0000, resp_rdata, dq_out, dq_in, d, w, ref_d;
   dps_exp_t          exp_q[$];
   dps_exp_t          e;
   int                fail_count = 0, n_tests = 0, cycles = 0;
   int                seed;

   dps_host uut (.core_clk, .arst_n, .req_valid, .req_ready, .req_op, .req_flag, .req_addr,
      .req_lanes, .req_wdata, .resp_valid, .resp_rdata, .resp_granted, .retain_req,
      .mem_addr, .chip_select_n, .flag_select_n, .high_lane_select_n, .low_lane_select_n,
      .rw_n, .out_enable_n, .dq_out, .dq_oe, .dq_in, .busy_n_in);
   dps_mem_model u_mem (.core_clk, .mem_addr, .chip_select_n, .flag_select_n,
      .high_lane_select_n, .low_lane_select_n, .rw_n, .out_enable_n, .dq_out, .dq_oe,
      .dq_in, .busy_hold, .far_holds_flag, .busy_n_in);

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic print_verdict();
      if (fail_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end
      else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want,
                        input string what);
      n_tests++;
      if (got !== want) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask : check

   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] l);
      return {{8{l[1] || l == 2'h0}}, {8{l[0] || l == 2'h0}}};
   endfunction : lane_mask

   // Waits for ready, hands over one request and queues its expected answer
   task automatic send(input dps_op_t op, input logic fl, input logic [ADDR_W-1:0] ad,
                       input logic [1:0] ln, input logic [DATA_W-1:0] wd,
                       input logic [DATA_W-1:0] ed, input logic eg, input logic ug);
      int n;
      n = 0;
      @(posedge core_clk);
      while (req_ready !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      exp_q.push_back(dps_exp_t'{ed, eg, ug});
      req_valid <= 1'b1;
      req_op <= op;
      req_flag <= fl;
      req_addr <= ad;
      req_lanes <= ln;
      req_wdata <= wd;
      @(posedge core_clk);
      req_valid <= 1'b0;
   endtask : send

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles > 3000) begin
         fail_count++;
         print_verdict();
      end
      else if (resp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(16'h0001, 16'h0000, "spare answer");
         end
         else begin
            e = exp_q.pop_front();
            if (e.use_grant) check(DATA_W'(resp_granted), DATA_W'(e.grant), "grant");
            else check(resp_rdata, e.data, "answer data");
         end
      end
   end

   initial begin
      seed = 32'haceac4df;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         a = ADDR_W'($random(seed));
         d = DATA_W'($random(seed));
         w = DATA_W'($random(seed));
         lanes = i[1:0];
         rl = 2'($random(seed));
         ref_d = (d & ~lane_mask(lanes)) | (w & lane_mask(lanes));
         send(DPS_OP_WRITE, 1'b0, a, 2'h3, d, 16'h0000, 1'b0, 1'b0);
         send(DPS_OP_WRITE, 1'b0, a, lanes, w, 16'h0000, 1'b0, 1'b0);
         send(DPS_OP_READ, 1'b0, a, rl, w, ref_d & lane_mask(rl), 1'b0, 1'b0);
      end
      w = DATA_W'($random(seed));
      send(DPS_OP_WRITE, 1'b0, a, 2'h3, w, 16'h0000, 1'b0, 1'b0);
      // Busy lands inside the write pulse, so the write must be redone
      @(posedge core_clk);
      busy_hold <= 1'b1;
      repeat (4) @(posedge core_clk);
      busy_hold <= 1'b0;
      send(DPS_OP_READ, 1'b0, a, 2'h3, 16'h0000, w, 1'b0, 1'b0);
      d = DATA_W'($random(seed));
      for (int j = 0; j < 2; j++) begin
         send(j ? DPS_OP_READ : DPS_OP_WRITE, 1'b0, a, 2'h3, d, j ? d : 16'h0000, 1'b0,
              1'b0);
         busy_hold <= 1'b1;
         repeat (6) begin
            @(posedge core_clk);
            check(DATA_W'(rw_n), 16'h0001, "write under busy");
         end
         busy_hold <= 1'b0;
      end
      send(DPS_OP_READ, 1'b1, 14'h0003, 2'h3, 16'h0000, 16'hffff, 1'b0, 1'b0);
      for (int j = 0; j < 2; j++) begin
         far_holds_flag <= j[0];
         send(DPS_OP_CLAIM, 1'b1, 14'h0003, 2'h3, 16'h0000, 16'h0000, !j[0], 1'b1);
         send(DPS_OP_WRITE, 1'b1, 14'h0003, 2'h3, 16'h0001, 16'h0000, 1'b0, 1'b0);
      end
      repeat (6) @(posedge core_clk);
      retain_req <= 1'b1;
      req_valid <= 1'b1;
      repeat (8) begin
         @(posedge core_clk);
         check(DATA_W'(chip_select_n), 16'h0001, "select in retention");
      end
      req_valid <= 1'b0;
      retain_req <= 1'b0;
      arst_n <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      check(DATA_W'({req_ready, chip_select_n, rw_n, dq_oe}), 16'h0006, "reset pins");
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(DATA_W'(req_ready), 16'h0000, "ready after reset");
      send(DPS_OP_READ, 1'b0, a, 2'h0, 16'h0000, d, 1'b0, 1'b0);
      repeat (10) @(posedge core_clk);
      check(DATA_W'(exp_q.size()), 16'h0000, "answers missing");
      print_verdict();
   end
endmodule : tb
